// ==== logic/iepr_defines.svh ====
`ifndef IEPR_DEFINES_SVH
`define IEPR_DEFINES_SVH

// register indices; byte address is four times the index
`define IEPR_IDX_EDGE_0_3 8'ha4
`define IEPR_IDX_EDGE_4_7 8'ha5
`define IEPR_IDX_TFLAG 8'ha6
`define IEPR_IDX_EDGE_UP 8'ha7
`define IEPR_IDX_EN_A 8'ha8
`define IEPR_IDX_EN_B 8'ha9
`define IEPR_IDX_EN_C 8'haa
`define IEPR_IDX_EN_D 8'hab
`define IEPR_IDX_LVL_LO 8'hb8
`define IEPR_IDX_EFLAG 8'hc0
`define IEPR_IDX_LVL_HI 8'hf8
`define IEPR_IDX_EVT_STS 8'hd0
`define IEPR_IDX_EVT_MASK 8'hd1

`define IEPR_RST_VAL 8'h00

// writable bits per register
`define IEPR_KEEP_A 8'hbf
`define IEPR_KEEP_B 8'h3d
`define IEPR_KEEP_C 8'h3f
`define IEPR_KEEP_D 8'h1f
`define IEPR_KEEP_LVL 8'h3f
`define IEPR_KEEP_TFLAG 8'hef
`define IEPR_KEEP_EVT 8'h0f

`define IEPR_GATE_BIT 7

// timer_ext_flags bit positions
`define IEPR_TF_EXT8 0
`define IEPR_TF_EXT10 1
`define IEPR_TF_EXT11 2
`define IEPR_TF_EXT12 3
`define IEPR_TF_T3 5
`define IEPR_TF_T0M 6
`define IEPR_TF_T0OVF 7

// source numbers
`define IEPR_SRC_EXT10 5'h00
`define IEPR_SRC_EXT11 5'h01
`define IEPR_SRC_EXTGRP 5'h05
`define IEPR_SRC_EXT8 5'h06
`define IEPR_SRC_EXT12 5'h0b
`define IEPR_SRC_T0OVF 5'h0c
`define IEPR_SRC_T0M 5'h0d
`define IEPR_SRC_T3 5'h10
// sources latched inside, not backed by a flag register
`define IEPR_PERIPH_SRC 24'h7ec71c

`define IEPR_EDGE_NONE 2'b00
`define IEPR_EDGE_BOTH 2'b11

`endif

// ==== logic/iepr_pkg.sv ====
package iepr_pkg;

  typedef struct packed {
    logic req;
    logic [4:0] vec;
    logic [1:0] lvl;
  } iepr_offer_type;

  typedef struct packed {
    logic [7:0] edge_lo;
    logic [7:0] edge_hi;
    logic [7:0] tflag;
    logic [7:0] edge_up;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] en_c;
    logic [7:0] en_d;
    logic [7:0] lvl_lo;
    logic [7:0] eflag;
    logic [7:0] lvl_hi;
    logic [7:0] evt_sts;
    logic [7:0] evt_mask;
    logic [23:0] pend;
    logic wb_ack;
    logic [7:0] rdat;
    iepr_offer_type offer;
  } iepr_state_type;

  typedef struct packed {
    logic prev;
  } iepr_edge_state_type;

endpackage

// ==== logic/iepr_edge_det.sv ====
`timescale 1ns/1ns
`include "iepr_defines.svh"
module iepr_edge_det (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic [1:0] sel_i,
  output logic hit_o
);
  iepr_pkg::iepr_edge_state_type s_ff;
  iepr_pkg::iepr_edge_state_type nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.prev = pin_i;
  end

  // follows the pin under reset too, so release shows no false edge
  always_ff @(posedge clk_i) begin
    s_ff <= nxt_s;
  end

  // bit 0 selects rising, bit 1 falling
  assign hit_o = (sel_i[0] & pin_i & ~s_ff.prev) |
                 (sel_i[1] & ~pin_i & s_ff.prev);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_edge_none;
    (sel_i == `IEPR_EDGE_NONE) |-> !hit_o;
  endproperty
  a_edge_none: assert property (p_edge_none)
    else $error("edge seen with detection off");

  property p_edge_both;
    ##1 (sel_i == `IEPR_EDGE_BOTH) && (pin_i != $past(pin_i)) |-> hit_o;
  endproperty
  a_edge_both: assert property (p_edge_both)
    else $error("both-edge mode missed a change");

endmodule // iepr_edge_det

// ==== logic/iepr_regs.sv ====
`timescale 1ns/1ns
`include "iepr_defines.svh"
// How it works
// - enable bank a bit 7 gates every maskable interrupt offer on offer_o; irq_o is not gated.
// - bank a bits 5..0: ext group, serial1 tx/rx/twowire, lines 11, 10.
// - bank b: line 12, serial0 tx, rx, twowire, line 8 at 5,4,3,2,0.
// - bank c bits 5..0: timer4, timer3..0 match, timer0 overflow.
// - bank d bits 4..0: interval, watchdog, watch, spi2, converter.
// - all eleven control registers reset to zero.
// - group level is high-bank bit x over low-bank bit x.
// - ext line n edge sets low flag bit n.
// - low ext flags ignore acknowledge; software writes zero.
// - edge field 00 none, 01 rise, 10 fall, 11 both.
// - lines 7..4 and 3..0 fields sit in pairs from the bottom.
// - timer/ext flags: t0 ovf, t0 match, t3, lines 12,11,10,8.
// - t0 overflow flag clears on write zero or acknowledge.
// - other timer/ext flags clear on write zero or acknowledge.
// - 24 sources form six groups of four sharing one level.
// - equal levels: lower source number served first.
// - upper edge register holds lines 12, 11, 10, 8 fields.
module iepr_regs #(
  parameter int ADR_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [7:0] ext_line_i,
  input wire logic [3:0] ext_upper_i,
  input wire logic [23:0] src_evt_i,
  input wire logic int_ack_i,
  output iepr_pkg::iepr_offer_type offer_o,
  output logic irq_o
);
  iepr_pkg::iepr_state_type s_ff;
  iepr_pkg::iepr_state_type nxt_s;

  logic [11:0] hit;
  logic [11:0] lines;
  logic [23:0] fields;
  logic [23:0] pv;
  logic [23:0] en;
  logic [23:0] pclr;
  logic [7:0] tclr;
  logic [7:0] tset;
  logic [7:0] idx;
  logic [7:0] wd;
  logic [7:0] rd;
  logic [3:0] ev;
  logic wr;
  logic start;
  logic mapped;
  logic ack_clr;
  logic found;
  logic [1:0] cur_lvl;
  logic [1:0] best_lvl;
  logic [4:0] best_idx;

  assign lines = {ext_upper_i, ext_line_i};
  assign fields = {s_ff.edge_up, s_ff.edge_hi,
                   s_ff.edge_lo};

  for (genvar g = 0; g < 12; g++) begin : g_edge
    iepr_edge_det u_det (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(lines[g]),
      .sel_i(fields[2*g +: 2]),
      .hit_o(hit[g])
    );
  end

  always_comb begin
    nxt_s = s_ff;
    idx = adr_i[9:2];
    wd = dat_i[7:0];
    start = cyc_i && stb_i && !s_ff.wb_ack;
    // a write lands on the edge where the master sees ack
    wr = cyc_i && stb_i && we_i && s_ff.wb_ack && sel_i[0];
    rd = 8'h00;
    mapped = 1'b1;
    tclr = 8'h00;
    tset = 8'h00;
    pclr = 24'h000000;
    ev = 4'h0;
    found = 1'b0;
    cur_lvl = 2'b00;
    best_lvl = 2'b00;
    best_idx = 5'h00;

    // read decode
    if (idx == `IEPR_IDX_EDGE_0_3) begin
      rd = s_ff.edge_lo;
    end else if (idx == `IEPR_IDX_EDGE_4_7) begin
      rd = s_ff.edge_hi;
    end else if (idx == `IEPR_IDX_TFLAG) begin
      rd = s_ff.tflag;
    end else if (idx == `IEPR_IDX_EDGE_UP) begin
      rd = s_ff.edge_up;
    end else if (idx == `IEPR_IDX_EN_A) begin
      rd = s_ff.en_a;
    end else if (idx == `IEPR_IDX_EN_B) begin
      rd = s_ff.en_b;
    end else if (idx == `IEPR_IDX_EN_C) begin
      rd = s_ff.en_c;
    end else if (idx == `IEPR_IDX_EN_D) begin
      rd = s_ff.en_d;
    end else if (idx == `IEPR_IDX_LVL_LO) begin
      rd = s_ff.lvl_lo;
    end else if (idx == `IEPR_IDX_EFLAG) begin
      rd = s_ff.eflag;
    end else if (idx == `IEPR_IDX_LVL_HI) begin
      rd = s_ff.lvl_hi;
    end else if (idx == `IEPR_IDX_EVT_STS) begin
      rd = s_ff.evt_sts;
    end else if (idx == `IEPR_IDX_EVT_MASK) begin
      rd = s_ff.evt_mask;
    end else begin
      mapped = 1'b0;
    end

    // write decode; reserved bits are masked off
    if (wr) begin
      if (idx == `IEPR_IDX_EDGE_0_3) begin
        nxt_s.edge_lo = wd;
      end else if (idx == `IEPR_IDX_EDGE_4_7) begin
        nxt_s.edge_hi = wd;
      end else if (idx == `IEPR_IDX_TFLAG) begin
        nxt_s.tflag = wd & `IEPR_KEEP_TFLAG;
      end else if (idx == `IEPR_IDX_EDGE_UP) begin
        nxt_s.edge_up = wd;
      end else if (idx == `IEPR_IDX_EN_A) begin
        nxt_s.en_a = wd & `IEPR_KEEP_A;
      end else if (idx == `IEPR_IDX_EN_B) begin
        nxt_s.en_b = wd & `IEPR_KEEP_B;
      end else if (idx == `IEPR_IDX_EN_C) begin
        nxt_s.en_c = wd & `IEPR_KEEP_C;
      end else if (idx == `IEPR_IDX_EN_D) begin
        nxt_s.en_d = wd & `IEPR_KEEP_D;
      end else if (idx == `IEPR_IDX_LVL_LO) begin
        nxt_s.lvl_lo = wd & `IEPR_KEEP_LVL;
      end else if (idx == `IEPR_IDX_EFLAG) begin
        nxt_s.eflag = wd;
      end else if (idx == `IEPR_IDX_LVL_HI) begin
        nxt_s.lvl_hi = wd & `IEPR_KEEP_LVL;
      end else if (idx == `IEPR_IDX_EVT_STS) begin
        nxt_s.evt_sts = s_ff.evt_sts & ~wd;
      end else if (idx == `IEPR_IDX_EVT_MASK) begin
        nxt_s.evt_mask = wd & `IEPR_KEEP_EVT;
      end
    end

    // acknowledge clears the source that was on offer, except the ext group
    ack_clr = int_ack_i && s_ff.offer.req;
    if (ack_clr) begin
      case (s_ff.offer.vec)
        `IEPR_SRC_EXT8: tclr[`IEPR_TF_EXT8] = 1'b1;
        `IEPR_SRC_EXT10: tclr[`IEPR_TF_EXT10] = 1'b1;
        `IEPR_SRC_EXT11: tclr[`IEPR_TF_EXT11] = 1'b1;
        `IEPR_SRC_EXT12: tclr[`IEPR_TF_EXT12] = 1'b1;
        `IEPR_SRC_T0OVF: tclr[`IEPR_TF_T0OVF] = 1'b1;
        `IEPR_SRC_T0M: tclr[`IEPR_TF_T0M] = 1'b1;
        `IEPR_SRC_T3: tclr[`IEPR_TF_T3] = 1'b1;
        `IEPR_SRC_EXTGRP: tclr = 8'h00;
        default: pclr[s_ff.offer.vec] = 1'b1;
      endcase
    end

    tset[`IEPR_TF_EXT8] = hit[8];
    tset[`IEPR_TF_EXT10] = hit[9];
    tset[`IEPR_TF_EXT11] = hit[10];
    tset[`IEPR_TF_EXT12] = hit[11];
    tset[`IEPR_TF_T3] = src_evt_i[`IEPR_SRC_T3];
    tset[`IEPR_TF_T0M] = src_evt_i[`IEPR_SRC_T0M];
    tset[`IEPR_TF_T0OVF] = src_evt_i[`IEPR_SRC_T0OVF];

    // sets win over write-zero and acknowledge in the same cycle
    nxt_s.tflag = (nxt_s.tflag & ~tclr) | tset;
    nxt_s.eflag = nxt_s.eflag | hit[7:0];
    nxt_s.pend = (s_ff.pend & ~pclr) | (src_evt_i & `IEPR_PERIPH_SRC);

    // pending view of all 24 sources
    pv = s_ff.pend & `IEPR_PERIPH_SRC;
    pv[`IEPR_SRC_EXT10] = s_ff.tflag[`IEPR_TF_EXT10];
    pv[`IEPR_SRC_EXT11] = s_ff.tflag[`IEPR_TF_EXT11];
    pv[`IEPR_SRC_EXTGRP] = |s_ff.eflag;
    pv[`IEPR_SRC_EXT8] = s_ff.tflag[`IEPR_TF_EXT8];
    pv[`IEPR_SRC_EXT12] = s_ff.tflag[`IEPR_TF_EXT12];
    pv[`IEPR_SRC_T0OVF] = s_ff.tflag[`IEPR_TF_T0OVF];
    pv[`IEPR_SRC_T0M] = s_ff.tflag[`IEPR_TF_T0M];
    pv[`IEPR_SRC_T3] = s_ff.tflag[`IEPR_TF_T3];

    // bank bits 5..0 line up with source numbers 6k..6k+5
    en = {s_ff.en_d[5:0], s_ff.en_c[5:0],
          s_ff.en_b[5:0], s_ff.en_a[5:0]};

    // ascending scan, strict compare keeps the lowest number on a tie
    for (int i = 0; i < 24; i++) begin
      cur_lvl = {s_ff.lvl_hi[i/4], s_ff.lvl_lo[i/4]};
      if (pv[i] && en[i] && (!found || cur_lvl > best_lvl)) begin
        found = 1'b1;
        best_lvl = cur_lvl;
        best_idx = 5'(i);
      end
    end

    // held low for one cycle after an acknowledge so no stale offer
    nxt_s.offer.req = found && s_ff.en_a[`IEPR_GATE_BIT] &&
                      !int_ack_i;
    nxt_s.offer.vec = best_idx;
    nxt_s.offer.lvl = best_lvl;

    // bus slave: ack one cycle after the request
    nxt_s.wb_ack = start;
    if (start) begin
      nxt_s.rdat = rd;
    end

    ev[0] = |hit;
    ev[1] = |tset[7:5];
    ev[2] = ack_clr;
    ev[3] = start && !mapped;
    nxt_s.evt_sts = nxt_s.evt_sts | {4'h0, ev};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign ack_o = s_ff.wb_ack;
  assign dat_o = {24'h000000, s_ff.rdat};
  assign offer_o = s_ff.offer;
  assign irq_o = |(s_ff.evt_sts & s_ff.evt_mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_gate_off;
    !s_ff.en_a[`IEPR_GATE_BIT] |=> !offer_o.req;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("offer made with global gate off");

  property p_bank_a_resv;
    s_ff.en_a[6] == 1'b0;
  endproperty
  a_bank_a_resv: assert property (p_bank_a_resv)
    else $error("bank a bit 6 set");

  property p_bank_b_resv;
    s_ff.en_b[7:6] == 2'b00 && s_ff.en_b[1] == 1'b0;
  endproperty
  a_bank_b_resv: assert property (p_bank_b_resv)
    else $error("bank b reserved bit set");

  property p_bank_cd_resv;
    s_ff.en_c[7:6] == 2'b00 && s_ff.en_d[7:5] == 3'b000;
  endproperty
  a_bank_cd_resv: assert property (p_bank_cd_resv)
    else $error("bank c or d reserved bit set");

  property p_reset_zero;
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> (s_ff.en_a == `IEPR_RST_VAL && s_ff.en_d == `IEPR_RST_VAL &&
               s_ff.lvl_hi == `IEPR_RST_VAL && s_ff.eflag == `IEPR_RST_VAL &&
               s_ff.tflag == `IEPR_RST_VAL && s_ff.edge_up == `IEPR_RST_VAL);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("register not zero after reset");

  property p_level;
    offer_o.req && $stable(s_ff.lvl_hi) && $stable(s_ff.lvl_lo) |->
      offer_o.lvl == {s_ff.lvl_hi[offer_o.vec[4:2]],
                      s_ff.lvl_lo[offer_o.vec[4:2]]};
  endproperty
  a_level: assert property (p_level)
    else $error("offered level does not match its group");

  property p_ext_set;
    hit[0] |=> s_ff.eflag[0];
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("edge on line 0 did not set its flag");

  sequence s_no_eflag_write;
    !(wr && idx == `IEPR_IDX_EFLAG);
  endsequence

  property p_eflag_hold;
    s_no_eflag_write |=> (s_ff.eflag & $past(s_ff.eflag)) ==
                         $past(s_ff.eflag);
  endproperty
  a_eflag_hold: assert property (p_eflag_hold)
    else $error("low ext flag cleared without a write");

  sequence s_ack_t0ovf;
    offer_o.req && offer_o.vec == `IEPR_SRC_T0OVF && int_ack_i &&
    !src_evt_i[`IEPR_SRC_T0OVF];
  endsequence

  property p_t0ovf_ack;
    s_ack_t0ovf |=> !s_ff.tflag[`IEPR_TF_T0OVF] ##1 !offer_o.req ||
                    offer_o.vec != `IEPR_SRC_T0OVF;
  endproperty
  a_t0ovf_ack: assert property (p_t0ovf_ack)
    else $error("acknowledge left timer 0 overflow pending");

  property p_t3_ack;
    offer_o.req && offer_o.vec == `IEPR_SRC_T3 && int_ack_i &&
    !src_evt_i[`IEPR_SRC_T3] |=> !s_ff.tflag[`IEPR_TF_T3];
  endproperty
  a_t3_ack: assert property (p_t3_ack)
    else $error("acknowledge left timer 3 flag set");

  property p_tflag_resv;
    s_ff.tflag[4] == 1'b0 && s_ff.lvl_hi[7:6] == 2'b00;
  endproperty
  a_tflag_resv: assert property (p_tflag_resv)
    else $error("reserved bit set");

  property p_masked_hold;
    s_ff.tflag[`IEPR_TF_T0M] && !s_ff.en_c[1] &&
    !(wr && idx == `IEPR_IDX_TFLAG) |=> s_ff.tflag[`IEPR_TF_T0M];
  endproperty
  a_masked_hold: assert property (p_masked_hold)
    else $error("masked flag was lost");

  property p_wb_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus ack not one cycle after request");

endmodule // iepr_regs

// ==== testbench/iepr_core_model.sv ====
`timescale 1ns/1ns
// core side: takes the offered source after dly_i cycles, pulses acknowledge
module iepr_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [3:0] dly_i,
  input wire iepr_pkg::iepr_offer_type offer_i,
  output logic int_ack_o,
  output logic [4:0] ack_vec_o
);
  logic [3:0] wait_ff;

  // no second pulse in the cycle where the design still shows req
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_ack_o <= 1'b0;
      ack_vec_o <= 5'h00;
      wait_ff <= 4'h0;
    end else begin
      int_ack_o <= 1'b0;
      if (en_i && offer_i.req && !int_ack_o) begin
        if (wait_ff >= dly_i) begin
          int_ack_o <= 1'b1;
          ack_vec_o <= offer_i.vec;
          wait_ff <= 4'h0;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end else begin
        wait_ff <= 4'h0;
      end
    end
  end
endmodule // iepr_core_model

// ==== testbench/interrupt_enable_priority_regs_tb.sv ====
`timescale 1ns/1ns
module interrupt_enable_priority_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [7:0] ext_line = 8'h00;
  logic [3:0] ext_upper = 4'h0;
  logic [23:0] src_evt = 24'h0;
  logic int_ack;
  logic irq;
  logic core_en = 1'b0;
  logic [3:0] core_dly = 4'h0;
  logic [4:0] ack_vec;
  iepr_pkg::iepr_offer_type offer;
  int err_total = 0;
  int cmp_count = 0;
  localparam logic [7:0] IDX_L [11] = '{8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8,
    8'ha9, 8'haa, 8'hab, 8'hb8, 8'hc0, 8'hf8};
  localparam logic [7:0] KEEP_L [11] = '{8'hff, 8'hff, 8'hef, 8'hff, 8'hbf,
    8'h3d, 8'h3f, 8'h1f, 8'h3f, 8'hff, 8'h3f};
  localparam logic [4:0] SRC_L [7] = '{5'h0c, 5'h0d, 5'h10, 5'h06, 5'h00,
    5'h01, 5'h0b};
  localparam logic [7:0] ENR_L [7] = '{8'haa, 8'haa, 8'haa, 8'ha9, 8'ha8,
    8'ha8, 8'ha9};
  localparam logic [7:0] ENV_L [7] = '{8'h01, 8'h02, 8'h10, 8'h01, 8'h81,
    8'h82, 8'h20};
  localparam logic [7:0] FLG_L [7] = '{8'h80, 8'h40, 8'h20, 8'h01, 8'h02,
    8'h04, 8'h08};
  localparam logic [7:0] LO_L [5] = '{8'h08, 8'h00, 8'h0a, 8'h0a, 8'h00};
  localparam logic [7:0] HI_L [5] = '{8'h00, 8'h08, 8'h08, 8'h0a, 8'h02};
  localparam logic [7:0] EX_L [5] = '{8'hb1, 8'hb2, 8'hb3, 8'h9b, 8'h9a};

  always #10 clk_i = ~clk_i;

  iepr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .ext_line_i(ext_line), .ext_upper_i(ext_upper),
    .src_evt_i(src_evt), .int_ack_i(int_ack), .offer_o(offer),
    .irq_o(irq));
  iepr_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .en_i(core_en),
    .dly_i(core_dly), .offer_i(offer), .int_ack_o(int_ack),
    .ack_vec_o(ack_vec));

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    chk("bus ack", 32'h1, {31'h0, ack_o});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string s, input logic [7:0] a,
    input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(s, {24'h0, e}, q);
  endtask

  task automatic set_line(input int k, input logic v);
    @(posedge clk_i);
    if (k < 8) ext_line[k] <= v;
    else ext_upper[k-8] <= v;
  endtask

  task automatic wait_ack(input logic [4:0] v);
    int n;
    n = 0;
    while (int_ack !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk("ack seen", 32'h1, {31'h0, int_ack});
    chk("acked source", {27'h0, v}, {27'h0, ack_vec});
  endtask

  task automatic t_regs();
    foreach (IDX_L[i]) rd_chk("reset value", IDX_L[i], 8'h00);
    foreach (IDX_L[i]) wr(IDX_L[i], 8'hff);
    foreach (IDX_L[i])
      rd_chk("bits", IDX_L[i],
        KEEP_L[i]);
    foreach (IDX_L[i]) wr(IDX_L[i], 8'h00);
    rd_chk("unmapped read", 8'h10, 8'h00);
    cycles(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'hd1, 8'h08);
    cycles(2);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(8'hd0, 8'h08);
    cycles(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(8'hd1, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_edge_map();
    logic [7:0] er;
    logic [7:0] fr;
    for (int k = 0; k < 12; k++) begin
      er = (k < 4) ? 8'ha4 : (k < 8) ? 8'ha5 : 8'ha7;
      fr = (k < 8) ? 8'hc0 : 8'ha6;
      wr(er, 8'h01 << (2 * (k % 4)));
      set_line(k, 1'b1);
      cycles(3);
      rd_chk("line flag", fr,
        8'h01 << (k % 8));
      set_line(k, 1'b0);
      cycles(2);
      wr(fr, 8'h00);
      wr(er, 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'ha4, c[7:0]);
      set_line(0, 1'b1);
      cycles(3);
      rd_chk("rise flag", 8'hc0, {7'h0, c[0]});
      wr(8'hc0, 8'h00);
      set_line(0, 1'b0);
      cycles(3);
      rd_chk("fall flag", 8'hc0, {7'h0, c[1]});
      wr(8'hc0, 8'h00);
    end
    $display("t_edge_map done");
  endtask

  task automatic t_group();
    core_en <= 1'b1;
    wr(8'ha4, 8'h01);
    wr(8'ha8, 8'ha0);
    set_line(0, 1'b1);
    wait_ack(5'h05);
    rd_chk("group flag kept", 8'hc0, 8'h01);
    wr(8'hc0, 8'h00);
    wr(8'ha8, 8'h00);
    wr(8'ha4, 8'h00);
    set_line(0, 1'b0);
    rd_chk("group flag cleared", 8'hc0, 8'h00);
    $display("t_group done");
  endtask

  task automatic t_gate();
    @(posedge clk_i);
    src_evt <= 24'h001000;
    @(posedge clk_i);
    src_evt <= 24'h000000;
    cycles(3);
    rd_chk("overflow flag", 8'ha6, 8'h80);
    wr(8'haa, 8'h01);
    cycles(3);
    chk("offer gated", 32'h0, {31'h0, offer.req});
    rd_chk("flag kept", 8'ha6, 8'h80);
    wr(8'ha8, 8'h80);
    wait_ack(5'h0c);
    rd_chk("flag acked", 8'ha6, 8'h00);
    wr(8'haa, 8'h00);
    $display("t_gate done");
  endtask

  task automatic t_clear();
    foreach (SRC_L[i]) begin
      core_dly <= i[3:0];
      wr(ENR_L[i], ENV_L[i]);
      wr(8'ha6, FLG_L[i]);
      wait_ack(SRC_L[i]);
      rd_chk("flag after ack", 8'ha6, 8'h00);
      wr(ENR_L[i], ENV_L[i] & 8'h80);
    end
    $display("t_clear done");
  endtask

  task automatic t_prio();
    core_en <= 1'b0;
    wr(8'ha6, 8'hc1);
    wr(8'haa, 8'h03);
    wr(8'ha9, 8'h01);
    cycles(3);
    chk("offer", 32'h98, {24'h0, offer});
    foreach (LO_L[i]) begin
      wr(8'hb8, LO_L[i]);
      wr(8'hf8, HI_L[i]);
      cycles(3);
      chk("offer", {24'h0, EX_L[i]},
        {24'h0, offer});
    end
    wr(8'ha6, 8'h00);
    cycles(3);
    chk("offer withdrawn", 32'h0, {31'h0, offer.req});
    $display("t_prio done");
  endtask

  initial begin
    #400000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_edge_map();
    t_group();
    t_gate();
    t_clear();
    t_prio();
    final_report();
  end
endmodule // interrupt_enable_priority_regs_tb
